// ---- pkg/hca_pkg.sv ----
// Purpose: Constants and types for the card host access controller.
// Assumes: 50 MHz system clock.
// Notes:   Times are kept in their own unit; cycle counts derive from them.
package hca_pkg;
    // ----------------------------------------
    // Clock and access timing
    // ----------------------------------------
    localparam int CLK_NS = 20;
    localparam int PIO_CYCLE_NS = 250;
    localparam int FAST_CYCLE_NS = 100;
    localparam int SETUP_NS = 30;
    // Strobe and recovery each take half a cycle, rounded up
    localparam int STB_CYC = (PIO_CYCLE_NS / 2 + CLK_NS - 1) / CLK_NS;
    localparam int FAST_STB_CYC = (FAST_CYCLE_NS / 2 + CLK_NS - 1) / CLK_NS;
    localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
    // ----------------------------------------
    // Card power sequencing
    // ----------------------------------------
    localparam int PWR_OFF_US = 100;
    localparam int PWR_ON_US = 1000;
    localparam int PWR_OFF_CYC = PWR_OFF_US * 1000 / CLK_NS;
    localparam int PWR_ON_CYC = PWR_ON_US * 1000 / CLK_NS;
    localparam int CNT_W = 20;
    // ----------------------------------------
    // Configuration index and address map
    // ----------------------------------------
    localparam logic [1:0] CFG_MEM = 2'h0;
    localparam logic [1:0] CFG_IO_ANY = 2'h1;
    localparam logic [1:0] CFG_IO_PRI = 2'h2;
    localparam logic [1:0] CFG_IO_SEC = 2'h3;
    localparam logic [10:0] PRI_TF_BASE = 11'h1f0;
    localparam logic [10:0] PRI_CTL_BASE = 11'h3f6;
    localparam logic [10:0] SEC_TF_BASE = 11'h170;
    localparam logic [10:0] SEC_CTL_BASE = 11'h376;
    localparam logic [3:0] IRQ_LEGACY = 4'he;
    localparam logic [3:0] IRQ_NONE = 4'h0;
    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef enum logic [1:0] {
        K_COMMON = 2'b00,
        K_TASK = 2'b01,
        K_DMA = 2'b10
    } hca_kind_t;
    typedef enum logic [1:0] {
        W_BYTE = 2'b00,
        W_WORD = 2'b01,
        W_ODD = 2'b10
    } hca_width_t;
    typedef enum logic [2:0] {
        S_NOCARD = 3'b000,
        S_PWROFF = 3'b001,
        S_PWRON = 3'b010,
        S_IDLE = 3'b011,
        S_DECODE = 3'b100,
        S_SETUP = 3'b101,
        S_STROBE = 3'b110,
        S_RECOV = 3'b111
    } hca_state_t;
endpackage

// ---- pkg/hca_dec_if.sv ----
// Purpose: Carries a latched request to the pin decoder and its pattern back.
// Assumes: Decoder is purely combinational.
// Notes:   None.
`timescale 1ns/1ps
`default_nettype none
interface hca_dec_if;
    import hca_pkg::*;
    logic ide;
    logic bit8;
    logic [1:0] cfg_idx;
    hca_kind_t kind;
    hca_width_t width;
    logic [3:0] offs;
    logic [10:0] mem_addr;
    logic [10:0] io_base;
    logic [10:0] addr;
    logic reg_n;
    logic ce1_n;
    logic ce2_n;
    logic io_strobe;
    logic lane_lo;
    logic lane_hi;
    logic bad;
    modport ctl (output ide, bit8, cfg_idx, kind, width, offs, mem_addr, io_base,
                 input addr, reg_n, ce1_n, ce2_n, io_strobe, lane_lo, lane_hi, bad);
    modport dec (input ide, bit8, cfg_idx, kind, width, offs, mem_addr, io_base,
                 output addr, reg_n, ce1_n, ce2_n, io_strobe, lane_lo, lane_hi, bad);
endinterface
`default_nettype wire

// ---- design/hca_pin_dec.sv ----
// Purpose: Turns a request into card pin levels for PC Card or True IDE mode.
// Assumes: Task file offsets 0-F as in the contiguous map.
// Notes:   In True IDE the chip selects share the chip enable pins and DMACK
//          shares the attribute select pin.
`timescale 1ns/1ps
`default_nettype none
module hca_pin_dec (
    hca_dec_if.dec dif
);
    import hca_pkg::*;

    // ----------------------------------------
    // Address
    // ----------------------------------------
    wire is_task = (dif.kind == K_TASK);
    wire is_dma = (dif.kind == K_DMA);
    wire hi_blk = dif.offs[3];
    wire ctl_reg = hi_blk && (dif.offs[2:1] == 2'b11);
    wire [10:0] off_ext = {7'h00, dif.offs};
    wire [10:0] off_low = {8'h00, dif.offs[2:0]};
    wire [10:0] off_ctl = {10'h000, dif.offs[0]};
    wire [10:0] pri_addr = ctl_reg ? PRI_CTL_BASE + off_ctl : PRI_TF_BASE + off_low;
    wire [10:0] sec_addr = ctl_reg ? SEC_CTL_BASE + off_ctl : SEC_TF_BASE + off_low;
    wire [10:0] tf_addr =
        (dif.cfg_idx == CFG_MEM) ? off_ext :
        (dif.cfg_idx == CFG_IO_ANY) ? (dif.io_base | off_ext) :
        (dif.cfg_idx == CFG_IO_PRI) ? pri_addr : sec_addr;
    // Control block E/F lands on A2-A0 = 6/7 with CS1 low
    assign dif.addr = dif.ide ? off_low : (is_task ? tf_addr : dif.mem_addr);

    // ----------------------------------------
    // Chip enables and space
    // ----------------------------------------
    wire pc_ce1_n = (dif.width == W_ODD);
    wire pc_ce2_n = (dif.width == W_BYTE);
    wire ide_cs0_n = is_dma || hi_blk;
    wire ide_cs1_n = is_dma || !hi_blk;
    assign dif.ce1_n = dif.ide ? ide_cs0_n : pc_ce1_n;
    assign dif.ce2_n = dif.ide ? ide_cs1_n : pc_ce2_n;
    wire pc_io = is_task && (dif.cfg_idx != CFG_MEM);
    assign dif.reg_n = dif.ide ? !is_dma : !pc_io;
    assign dif.io_strobe = dif.ide || pc_io;

    // ----------------------------------------
    // Data lanes
    // ----------------------------------------
    wire ide_word = (is_dma || (is_task && dif.offs == 4'h0)) && !dif.bit8;
    assign dif.lane_lo = dif.ide || (dif.width != W_ODD);
    assign dif.lane_hi = dif.ide ? ide_word : (dif.width != W_BYTE);

    // ----------------------------------------
    // Refused requests
    // ----------------------------------------
    wire ide_bad = (dif.kind == K_COMMON) || (is_task && hi_blk && !ctl_reg);
    wire fixed_map = dif.cfg_idx[1];
    wire pc_bad = is_dma || (is_task && fixed_map && hi_blk && !ctl_reg);
    assign dif.bad = dif.ide ? ide_bad : pc_bad;
endmodule
`default_nettype wire

// ---- design/hca_host.sv ----
// Purpose: Host controller driving a flash card through its parallel pins.
// Assumes: Card pins are asynchronous; no card clock, no IORDY handshake.
// Notes:   Behaviour
// Behaviour
// - OE low through power-up selects True IDE
// - DMA read: both selects high, DMACK low
// - Faster than 250 ns needs every card
// - Advanced modes: 100 ns, PIO5-6, MDMA3-4
// - No advanced mode shared or long cable
// - No Ultra DMA beside non-UDMA card
// - Use fastest mode common to both
// - Config index selects register address map
// - Fixed maps use IRQ 14 or free
`timescale 1ns/1ps
`default_nettype none
module hca_host #(
    parameter int PWR_OFF_CYCLES = hca_pkg::PWR_OFF_CYC,
    parameter int PWR_ON_CYCLES = hca_pkg::PWR_ON_CYC
) (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    // User side
    input wire logic i_req,
    input wire logic i_wr,
    input wire hca_pkg::hca_kind_t i_kind,
    input wire hca_pkg::hca_width_t i_width,
    input wire logic [3:0] i_offs,
    input wire logic [10:0] i_mem_addr,
    input wire logic [15:0] i_wdata,
    input wire logic [1:0] i_cfg_idx,
    input wire logic [10:0] i_io_base,
    input wire logic i_want_ide,
    input wire logic i_ide_8bit,
    input wire logic i_fast_req,
    input wire logic i_udma_req,
    input wire logic i_two_cards,
    input wire logic i_long_cable,
    input wire logic i_peer_fast_ok,
    input wire logic i_peer_udma_ok,
    output logic o_busy,
    output logic o_done,
    output logic o_err,
    output logic [15:0] o_rdata,
    output logic o_ide_mode,
    output logic o_fast_mode,
    output logic o_udma_ok,
    output logic [3:0] o_irq_sel,
    // Card pins
    input wire logic i_card_det_n,
    input wire logic [15:0] i_dat,
    output logic o_card_pwr,
    output logic [10:0] o_addr,
    output logic o_reg_n,
    output logic o_ce1_n,
    output logic o_ce2_n,
    output logic o_oe_n,
    output logic o_we_n,
    output logic o_iord_n,
    output logic o_iowr_n,
    output logic [15:0] o_dat,
    output logic [15:0] o_dat_oe_n
);
    import hca_pkg::*;

    hca_dec_if dif ();
    hca_pin_dec u_dec (
        .dif(dif)
    );

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic [15:0] dat_s1_ff;
    logic [15:0] dat_s2_ff;
    logic cd_s1_ff;
    logic cd_s2_ff;
    always_ff @(posedge i_sys_clk)
    begin
        dat_s1_ff <= i_dat;
        dat_s2_ff <= dat_s1_ff;
        cd_s1_ff <= i_card_det_n;
        cd_s2_ff <= cd_s1_ff;
    end

    // ----------------------------------------
    // Mode selection
    // ----------------------------------------
    // Advanced timing only for one directly attached card
    wire fast_ok = i_fast_req && i_peer_fast_ok && !i_two_cards && !i_long_cable;
    wire udma_ok = i_udma_req && (!i_two_cards || i_peer_udma_ok);
    wire fixed_io = i_cfg_idx[1];
    wire [3:0] nxt_irq = fixed_io ? IRQ_LEGACY : IRQ_NONE;
    wire [CNT_W-1:0] stb_len = fast_ok ? CNT_W'(FAST_STB_CYC) : CNT_W'(STB_CYC);

    // ----------------------------------------
    // Request latch
    // ----------------------------------------
    hca_state_t state_ff;
    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] stb_ff;
    logic ide_ff;
    logic boot_ff;
    logic wr_ff;
    logic [15:0] wdata_ff;
    hca_kind_t kind_ff;
    hca_width_t width_ff;
    logic [3:0] offs_ff;
    logic [10:0] maddr_ff;
    wire take = (state_ff == S_IDLE) && i_req;
    always_ff @(posedge i_sys_clk)
    begin
        if (take)
        begin
            wr_ff <= i_wr;
            wdata_ff <= i_wdata;
            kind_ff <= i_kind;
            width_ff <= i_width;
            offs_ff <= i_offs;
            maddr_ff <= i_mem_addr;
            stb_ff <= stb_len;
        end
    end
    assign dif.ide = ide_ff;
    assign dif.bit8 = i_ide_8bit;
    assign dif.cfg_idx = i_cfg_idx;
    assign dif.kind = kind_ff;
    assign dif.width = width_ff;
    assign dif.offs = offs_ff;
    assign dif.mem_addr = maddr_ff;
    assign dif.io_base = i_io_base;

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    wire cnt_end = (cnt_ff == '0);
    wire card_gone = cd_s2_ff;
    wire [CNT_W-1:0] cnt_dec = cnt_ff - CNT_W'(1);
    hca_state_t nxt_state;
    logic [CNT_W-1:0] nxt_cnt;
    always_comb
    begin
        nxt_state = state_ff;
        nxt_cnt = cnt_end ? cnt_ff : cnt_dec;
        case (state_ff)
            S_NOCARD:
                if (!card_gone)
                begin
                    nxt_state = S_PWROFF;
                    nxt_cnt = CNT_W'(PWR_OFF_CYCLES);
                end
            S_PWROFF:
                if (cnt_end)
                begin
                    nxt_state = S_PWRON;
                    nxt_cnt = CNT_W'(PWR_ON_CYCLES);
                end
            S_PWRON:
                if (cnt_end)
                    nxt_state = S_IDLE;
            S_IDLE:
                if (i_req)
                    nxt_state = S_DECODE;
            S_DECODE:
            begin
                nxt_state = dif.bad ? S_IDLE : S_SETUP;
                nxt_cnt = CNT_W'(SETUP_CYC - 1);
            end
            S_SETUP:
                if (cnt_end)
                begin
                    nxt_state = S_STROBE;
                    nxt_cnt = stb_ff - CNT_W'(1);
                end
            S_STROBE:
                if (cnt_end)
                begin
                    nxt_state = S_RECOV;
                    nxt_cnt = stb_ff - CNT_W'(1);
                end
            S_RECOV:
                if (cnt_end)
                    nxt_state = S_IDLE;
            default:
                nxt_state = S_NOCARD;
        endcase
        if (card_gone)
            nxt_state = S_NOCARD;
    end

    // ----------------------------------------
    // Next pin levels
    // ----------------------------------------
    // Low already on the edge that raises card power, so the card sees it
    wire powering = (nxt_state == S_PWRON);
    wire in_cycle = (nxt_state == S_SETUP) || (nxt_state == S_STROBE) || (nxt_state == S_RECOV);
    wire strobe_on = (nxt_state == S_STROBE);
    wire drive = in_cycle && wr_ff && (nxt_state != S_RECOV);
    wire ide_sel = boot_ff && i_want_ide;
    wire nxt_ide = (state_ff == S_PWRON) ? ide_sel : ide_ff;
    wire [15:0] lane_mask = {{8{dif.lane_hi}}, {8{dif.lane_lo}}};
    // Card stays in True IDE only while OE is held at ground
    wire nxt_oe_n = (powering && ide_sel) || ide_ff ? 1'b0 :
                    !(strobe_on && !wr_ff && !dif.io_strobe);
    wire nxt_we_n = !(strobe_on && wr_ff && !dif.io_strobe);
    wire nxt_iord_n = !(strobe_on && !wr_ff && dif.io_strobe);
    wire nxt_iowr_n = !(strobe_on && wr_ff && dif.io_strobe);
    logic [15:0] nxt_dat_oe_n;
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi++)
        begin : g_lane
            assign nxt_dat_oe_n[gi] = !(drive && lane_mask[gi]);
        end
    endgenerate
    wire end_ok = (state_ff == S_RECOV) && cnt_end && !card_gone;
    wire end_bad = (state_ff == S_DECODE) && dif.bad;
    wire sample = (state_ff == S_STROBE) && cnt_end && !wr_ff;

    // ----------------------------------------
    // State and pin registers
    // ----------------------------------------
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rst_n)
        begin
            state_ff <= S_NOCARD;
            cnt_ff <= '0;
            ide_ff <= 1'b0;
            boot_ff <= 1'b1;
        end
        else
        begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            ide_ff <= card_gone ? 1'b0 : nxt_ide;
            // Only the first power-up after host reset may pick True IDE
            if (state_ff == S_PWRON && cnt_end)
                boot_ff <= 1'b0;
        end
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rst_n)
        begin
            o_card_pwr <= 1'b0;
            o_addr <= '0;
            o_reg_n <= 1'b1;
            o_ce1_n <= 1'b1;
            o_ce2_n <= 1'b1;
            o_oe_n <= 1'b1;
            o_we_n <= 1'b1;
            o_iord_n <= 1'b1;
            o_iowr_n <= 1'b1;
            o_dat <= '0;
            o_dat_oe_n <= '1;
        end
        else
        begin
            o_card_pwr <= (nxt_state == S_PWRON) || (nxt_state >= S_IDLE);
            o_addr <= in_cycle ? dif.addr : o_addr;
            o_reg_n <= in_cycle ? dif.reg_n : 1'b1;
            o_ce1_n <= in_cycle ? dif.ce1_n : 1'b1;
            o_ce2_n <= in_cycle ? dif.ce2_n : 1'b1;
            o_oe_n <= nxt_oe_n;
            o_we_n <= nxt_we_n;
            o_iord_n <= nxt_iord_n;
            o_iowr_n <= nxt_iowr_n;
            o_dat <= wdata_ff;
            o_dat_oe_n <= nxt_dat_oe_n;
        end
    end

    // ----------------------------------------
    // User status
    // ----------------------------------------
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rst_n)
        begin
            o_busy <= 1'b1;
            o_done <= 1'b0;
            o_err <= 1'b0;
            o_rdata <= '0;
            o_ide_mode <= 1'b0;
            o_fast_mode <= 1'b0;
            o_udma_ok <= 1'b0;
            o_irq_sel <= IRQ_NONE;
        end
        else
        begin
            o_busy <= (nxt_state != S_IDLE);
            o_done <= end_ok || end_bad;
            o_err <= end_bad;
            if (sample)
                o_rdata <= dat_s2_ff & lane_mask;
            o_ide_mode <= ide_ff;
            o_fast_mode <= fast_ok;
            o_udma_ok <= udma_ok;
            o_irq_sel <= nxt_irq;
        end
    end
endmodule
`default_nettype wire

// ---- tb/hca_host_assertions.sv ----
// Purpose: Pin-level checks on the card host controller.
// Assumes: One clock domain, synchronous active-low reset.
// Notes: Attached by bind at the foot of this file.
`timescale 1ns/1ps
`default_nettype none
module hca_host_assertions (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_ide_8bit,
    input wire logic i_udma_req,
    input wire logic i_two_cards,
    input wire logic i_peer_udma_ok,
    input wire logic o_ide_mode,
    input wire logic o_fast_mode,
    input wire logic o_udma_ok,
    input wire logic [10:0] o_addr,
    input wire logic o_reg_n,
    input wire logic o_ce1_n,
    input wire logic o_ce2_n,
    input wire logic o_oe_n,
    input wire logic o_we_n,
    input wire logic o_iord_n,
    input wire logic o_iowr_n,
    input wire logic [15:0] o_dat_oe_n
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);
    // ----------------------------------------
    // Lane, select and mode gating relations
    // ----------------------------------------
    standby_float_a: assert property ((o_ce1_n && o_ce2_n && o_reg_n) |-> o_dat_oe_n == 16'hffff)
        else $error("bus driven while card deselected");
    mem_read_float_a: assert property ((!o_ide_mode && !o_oe_n) |-> o_dat_oe_n == 16'hffff)
        else $error("host drives data during memory read");
    word_write_a: assert property ((!o_ide_mode && !o_we_n && !o_ce1_n && !o_ce2_n)
        |-> o_dat_oe_n == 16'h0000 && o_reg_n)
        else $error("word write lanes wrong");
    byte_write_a: assert property ((!o_ide_mode && !o_we_n && !o_ce1_n && o_ce2_n) |-> o_dat_oe_n == 16'hff00)
        else $error("byte write lanes wrong");
    odd_write_a: assert property ((!o_ide_mode && !o_we_n && o_ce1_n && !o_ce2_n) |-> o_dat_oe_n[15:8] == 8'h00)
        else $error("odd write upper lane not driven");
    ide_no_memory_a: assert property (o_ide_mode |-> o_we_n)
        else $error("memory write in ide mode");
    dma_read_sel_a: assert property ((o_ide_mode && !o_reg_n && !o_iord_n) |-> o_ce1_n && o_ce2_n)
        else $error("chip select during dma read");
    pio_write_word_a: assert property ((o_ide_mode && !o_iowr_n && o_reg_n && !o_ce1_n && o_addr[2:0] == 3'h0
        && !i_ide_8bit) |-> o_dat_oe_n == 16'h0000)
        else $error("data register write not full word");
    // Fast strobe is three cycles, so three is the safe hold span
    io_write_hold_a: assert property ($fell(o_iowr_n) |-> ($stable(o_addr) && $stable(o_dat_oe_n))[*3])
        else $error("address or lanes moved during write strobe");
    fast_gate_a: assert property (i_two_cards |=> !o_fast_mode)
        else $error("fast mode with two cards");
    udma_gate_a: assert property ((i_udma_req && i_two_cards && !i_peer_udma_ok) |=> !o_udma_ok)
        else $error("ultra dma allowed beside plain card");
endmodule
bind hca_host hca_host_assertions hca_host_assertions_inst (.*);
`default_nettype wire

// ---- tb/hca_card_model.sv ----
// Purpose: Behavioural card answering the host pins.
// Assumes: Read data is a fixed function of the address.
// Notes: Undriven lanes carry a pattern that changes every cycle.
`timescale 1ns/1ps
`default_nettype none
module hca_card_model (
    input wire logic i_sys_clk,
    input wire logic i_pwr,
    input wire logic [10:0] i_addr,
    input wire logic i_reg_n,
    input wire logic i_ce1_n,
    input wire logic i_ce2_n,
    input wire logic i_oe_n,
    input wire logic i_we_n,
    input wire logic i_iord_n,
    input wire logic i_iowr_n,
    input wire logic [15:0] i_dat,
    output logic [15:0] o_dat,
    output logic [15:0] o_wr_word
);
    logic ide = 1'b0;
    logic up = 1'b1;
    logic [15:0] pat = 16'h0000;
    wire logic dma;
    wire logic dreg;
    wire logic rd;
    wire logic wr;
    wire logic hi_on;
    wire logic lo_on;
    wire logic [7:0] k;
    wire logic [15:0] word;
    wire logic [7:0] lo_val;
    // ----------------------------------------
    // Decode
    // ----------------------------------------
    assign dma = ide && !i_reg_n;
    assign k = dma ? 8'h00 : i_addr[8:1];
    assign word = {8'hc3 ^ k, 8'h5a ^ k};
    assign dreg = dma || (!i_ce1_n && i_ce2_n && i_addr[2:0] == 3'h0);
    assign rd = (ide || !i_reg_n) ? !i_iord_n : !i_oe_n;
    assign wr = (ide || !i_reg_n) ? !i_iowr_n : !i_we_n;
    assign hi_on = rd && (ide ? dreg : !i_ce2_n);
    assign lo_on = rd && (ide ? (dma || !i_ce1_n || !i_ce2_n) : !i_ce1_n);
    assign lo_val = (!ide && i_ce2_n && i_addr[0]) ? word[15:8] : word[7:0];
    assign o_dat = {hi_on ? word[15:8] : pat[15:8], lo_on ? lo_val : pat[7:0]};
    // ----------------------------------------
    // Mode latch and write capture
    // ----------------------------------------
    always @(posedge i_sys_clk)
    begin
        pat <= {pat[14:0], ~pat[15]};
        // First cycle with power on decides the mode
        if (!i_pwr)
        begin
            up <= 1'b1;
        end
        else if (up)
        begin
            ide <= !i_oe_n;
            up <= 1'b0;
        end
        if (wr)
        begin
            o_wr_word <= {(ide ? dreg : !i_ce2_n) ? i_dat[15:8] : 8'h00,
                          (ide || !i_ce1_n) ? i_dat[7:0] : 8'h00};
        end
    end
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
// Purpose: Self-checking bench for the card host controller.
// Assumes: Short power-up counts, 50 MHz clock.
// Notes: Table rows first, then mode switches and removal.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import hca_pkg::*;
    typedef struct packed {
        logic wr;
        hca_kind_t k;
        hca_width_t w;
        logic [3:0] o;
        logic [10:0] a;
        logic [15:0] d;
        logic [15:0] e;
        logic err;
    } hca_row_t;
    logic i_sys_clk = 1'b0, i_rst_n = 1'b0, i_req = 1'b0, i_wr = 1'b0, i_want_ide = 1'b0, i_ide_8bit = 1'b0;
    logic i_fast_req = 1'b0, i_udma_req = 1'b0, i_two_cards = 1'b0, i_long_cable = 1'b0;
    logic i_peer_fast_ok = 1'b0, i_peer_udma_ok = 1'b0, i_card_det_n = 1'b0;
    hca_kind_t i_kind = K_COMMON;
    hca_width_t i_width = W_WORD;
    logic [3:0] i_offs = 4'h0;
    logic [10:0] i_mem_addr = 11'h000, i_io_base = 11'h000;
    logic [15:0] i_wdata = 16'h0000;
    logic [1:0] i_cfg_idx = 2'h0;
    wire logic [15:0] i_dat;
    logic o_busy, o_done, o_err, o_ide_mode, o_fast_mode, o_udma_ok, o_card_pwr, o_reg_n, o_ce1_n, o_ce2_n;
    logic o_oe_n, o_we_n, o_iord_n, o_iowr_n;
    logic [15:0] o_rdata, o_dat, o_dat_oe_n, card_dat, wr_word;
    logic [3:0] o_irq_sel;
    logic [10:0] o_addr;
    int fails = 0;
    int samples_checked = 0;
    int row_cycles = 0;
    hca_row_t rows [16] = '{
        '{1'b0, K_COMMON, W_WORD, 4'h0, 11'h024, 16'h0000, 16'hd148, 1'b0},
        '{1'b0, K_COMMON, W_BYTE, 4'h0, 11'h024, 16'h0000, 16'h0048, 1'b0},
        '{1'b0, K_COMMON, W_BYTE, 4'h0, 11'h025, 16'h0000, 16'h00d1, 1'b0},
        '{1'b0, K_COMMON, W_ODD, 4'h0, 11'h024, 16'h0000, 16'hd100, 1'b0},
        '{1'b0, K_COMMON, W_WORD, 4'h0, 11'h7fe, 16'h0000, 16'h3ca5, 1'b0},
        '{1'b1, K_COMMON, W_WORD, 4'h0, 11'h7fe, 16'hbeef, 16'hbeef, 1'b0},
        '{1'b1, K_COMMON, W_BYTE, 4'h0, 11'h001, 16'h1234, 16'h0034, 1'b0},
        '{1'b1, K_COMMON, W_ODD, 4'h0, 11'h100, 16'habcd, 16'hab00, 1'b0},
        '{1'b0, K_TASK, W_WORD, 4'h0, 11'h000, 16'h0000, 16'hc35a, 1'b0},
        '{1'b1, K_TASK, W_WORD, 4'h0, 11'h000, 16'h55aa, 16'h55aa, 1'b0},
        '{1'b0, K_DMA, W_WORD, 4'h0, 11'h000, 16'h0000, 16'hc35a, 1'b0},
        '{1'b1, K_DMA, W_WORD, 4'h0, 11'h000, 16'h0ff0, 16'h0ff0, 1'b0},
        '{1'b0, K_TASK, W_WORD, 4'he, 11'h000, 16'h0000, 16'h0059, 1'b0},
        '{1'b1, K_TASK, W_WORD, 4'he, 11'h000, 16'h0004, 16'h0004, 1'b0},
        '{1'b0, K_COMMON, W_WORD, 4'h0, 11'h024, 16'h0000, 16'h0000, 1'b1},
        '{1'b0, K_TASK, W_WORD, 4'h3, 11'h000, 16'h0000, 16'h005b, 1'b0}
    };
    assign i_dat = (o_dat & ~o_dat_oe_n) | (card_dat & o_dat_oe_n);
    hca_host #(.PWR_OFF_CYCLES(4), .PWR_ON_CYCLES(8)) hca_host_inst (.*);
    hca_card_model hca_card_model_inst (.i_sys_clk(i_sys_clk), .i_pwr(o_card_pwr), .i_addr(o_addr),
        .i_reg_n(o_reg_n), .i_ce1_n(o_ce1_n), .i_ce2_n(o_ce2_n), .i_oe_n(o_oe_n), .i_we_n(o_we_n),
        .i_iord_n(o_iord_n), .i_iowr_n(o_iowr_n), .i_dat(i_dat), .o_dat(card_dat), .o_wr_word(wr_word));
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        samples_checked++;
        if (got !== exp)
        begin
            fails++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic finish_test();
        $display("Checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
        begin
            $display("Simulation passed");
        end
        else
        begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic wait_idle();
        int n;
        n = 0;
        while (o_busy !== 1'b0 && n < 200)
        begin
            @(posedge i_sys_clk);
            #1;
            n++;
        end
        check({15'h0, o_busy}, 16'h0000, "idle");
    endtask
    task automatic do_reset(input logic ide);
        @(posedge i_sys_clk);
        i_want_ide <= ide;
        i_rst_n <= 1'b0;
        repeat (7) @(posedge i_sys_clk);
        #1;
        check(o_dat_oe_n, 16'hffff, "reset float");
        @(posedge i_sys_clk);
        i_rst_n <= 1'b1;
        wait_idle();
        check({15'h0, o_ide_mode}, {15'h0, ide}, "mode");
    endtask
    task automatic run_row(input hca_row_t r);
        int n;
        n = 0;
        @(posedge i_sys_clk);
        i_req <= 1'b1;
        i_kind <= r.k;
        i_width <= r.w;
        {i_wr, i_offs, i_mem_addr, i_wdata} <= {r.wr, r.o, r.a, r.d};
        @(posedge i_sys_clk);
        i_req <= 1'b0;
        do
        begin
            @(posedge i_sys_clk);
            #1;
            n++;
        end
        while (o_done !== 1'b1 && n < 40);
        row_cycles = n;
        check({15'h0, o_done}, 16'h0001, "done");
        check({15'h0, o_err}, {15'h0, r.err}, "refusal");
        if (!r.err)
        begin
            check(r.wr ? wr_word : o_rdata, r.e, "data");
        end
    endtask
    task automatic modes(input logic [3:0] ins, input logic [15:0] exp);
        @(posedge i_sys_clk);
        {i_fast_req, i_peer_fast_ok, i_udma_req, i_two_cards} <= ins;
        i_cfg_idx <= 2'h2;
        repeat (3) @(posedge i_sys_clk);
        #1;
        check({10'h0, o_fast_mode, o_udma_ok, o_irq_sel}, exp, "mode gating");
    endtask
    // ----------------------------------------
    // Clock, watchdog, main sequence
    // ----------------------------------------
    initial
    begin
        forever #10 i_sys_clk = ~i_sys_clk;
    end
    initial
    begin
        // About 430 cycles expected; generous margin
        repeat (20000) @(posedge i_sys_clk);
        fails++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        finish_test();
    end
    initial
    begin
        do_reset(1'b0);
        for (int i = 0; i < 8; i++) run_row(rows[i]);
        do_reset(1'b1);
        for (int i = 8; i < 16; i++) run_row(rows[i]);
        @(posedge i_sys_clk);
        i_ide_8bit <= 1'b1;
        run_row('{1'b0, K_TASK, W_WORD, 4'h0, 11'h000, 16'h0000, 16'h005a, 1'b0});
        @(posedge i_sys_clk);
        i_ide_8bit <= 1'b0;
        i_card_det_n <= 1'b1;
        repeat (10) @(posedge i_sys_clk);
        i_card_det_n <= 1'b0;
        repeat (4) @(posedge i_sys_clk);
        wait_idle();
        check({15'h0, o_ide_mode}, 16'h0000, "reinserted mode");
        run_row(rows[0]);
        modes(4'b1110, 16'h003e);
        run_row('{1'b1, K_COMMON, W_WORD, 4'h0, 11'h7fe, 16'h1357, 16'h1357, 1'b0});
        check(16'(row_cycles), 16'(1 + SETUP_CYC + 2 * FAST_STB_CYC), "fast cycle length");
        run_row('{1'b0, K_TASK, W_BYTE, 4'he, 11'h000, 16'h0000, 16'h00a1, 1'b0});
        check({5'h0, o_addr}, {5'h0, PRI_CTL_BASE}, "primary map");
        modes(4'b1111, 16'h000e);
        @(posedge i_sys_clk);
        i_peer_udma_ok <= 1'b1;
        modes(4'b1111, 16'h001e);
        finish_test();
    end
endmodule
`default_nettype wire
